// [src/lpmc_pkg.sv]
package lpmc_pkg;
  // Standby mode encodings
  localparam logic [2:0] MODE_STOP_WITH_SUPPLY_MODE = 3'h1;
  localparam logic [2:0] MODE_IDLE = 3'h3;
  localparam logic [2:0] MODE_POWER_CUT_STOP_MODE = 3'h5;
  // Register byte offsets
  localparam logic [7:0] ADDR_STBYCR = 8'h00;
  localparam logic [7:0] ADDR_KEEPRUN = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  // Standby control fields
  localparam int STBY_LSB = 0;
  localparam int DRVE_BIT = 16;
  localparam int PTKEEP_BIT = 17;
  localparam logic [2:0] STBY_RESET = 3'h3;
  // Module index
  localparam int NMOD = 20;
  localparam int M_CORE = 0;
  localparam int M_DMA = 1;
  localparam int M_ADC = 2;
  localparam int M_DAC = 3;
  localparam int M_USB = 4;
  localparam int M_SSP = 5;
  localparam int M_UART = 6;
  localparam int M_I2C = 7;
  localparam int M_WDT = 8;
  localparam int M_TMR = 9;
  localparam int M_MPT = 10;
  localparam int M_RMC = 11;
  localparam int M_RTC = 12;
  localparam int M_LVD = 13;
  localparam int M_EBI = 14;
  localparam int M_CG = 15;
  localparam int M_PLL = 16;
  localparam int M_OFD = 17;
  localparam int M_EXTERNAL_FAST_OSCILLATOR = 18;
  localparam int M_INTERNAL_FAST_OSCILLATOR = 19;
  // Fixed status matrix per mode: clock stop, selectable, supply cut
  localparam logic [19:0] IDLE_STOPCLK = 20'h0_0001;
  localparam logic [19:0] STOP_WITH_SUPPLY_MODE_STOPCLK = 20'h8_C703;
  localparam logic [19:0] STOP_WITH_SUPPLY_MODE_SEL = 20'h7_00EC;
  localparam logic [19:0] POWER_CUT_STOP_MODE_STOPCLK = 20'hC_8008;
  localparam logic [19:0] POWER_CUT_STOP_MODE_SEL = 20'h3_07F6;
  localparam logic [19:0] POWER_CUT_STOP_MODE_CUT = 20'h0_4001;
  localparam logic [19:0] KEEPRUN_RESET = 20'h0_0000;
  // Power states
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_IDLE = 2'b01,
    ST_STOP_WITH_SUPPLY_MODE = 2'b11,
    ST_POWER_CUT_STOP_MODE = 2'b10
  } lpmc_state_t;
endpackage

// [src/lpmc_top.sv]
// Functional notes
// - Decode 001 stop_with_supply_mode, 011 idle, 101 power_cut_stop_mode
// - Entering mode stops clocks per matrix
// - Power_cut_stop_mode cuts core, EBI, unkept modules
// - Stop_with_supply_mode selectable modules follow keep-run bits
// - Always-on modules never stopped in any mode
// - Stop_with_supply_mode port drive follows drive enable bit
// - Power_cut_stop_mode holds port pins when hold set
// - Reset or stop release selects internal oscillator
// - Idle keeps watchdog counting, clear blocked
// - Mode entered only on wait-for-interrupt
`timescale 1ns/1ns
`default_nettype none
module lpmc_top (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic wfi_exec,
  input wire logic core_halted,
  input wire logic wake_event,
  input wire logic wdt_clear_req,
  output logic wdt_clear,
  output logic wdt_run,
  output logic [19:0] clk_gate_en,
  output logic [19:0] supply_en,
  output logic port_drive_en,
  output logic port_hold,
  output logic sysclk_from_internal_fast_oscillator,
  output logic in_standby
);
  typedef struct packed {
    logic [1:0] rst_sync;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [2:0] stby;
    logic drve;
    logic ptkeep;
    logic [19:0] keeprun;
    logic pend;
    logic [2:0] pend_mode;
    lpmc_pkg::lpmc_state_t state;
    logic internal_fast_oscillator_sel;
    logic [19:0] gate;
    logic [19:0] supply;
    logic hold;
  } lpmc_regs_t;

  lpmc_regs_t q, d;
  logic rst_q;
  logic rst_n_i;
  logic [19:0] stop_mask;
  logic [19:0] cut_mask;

  ////////////////////////////////////////////////////////////////////////
  // Reset release through two flip-flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_q <= 1'b0;
      rst_n_i <= 1'b0;
    end else begin
      rst_q <= 1'b1;
      rst_n_i <= rst_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Fixed matrix lookup; keep-run only rescues selectable modules
  always_comb begin
    stop_mask = 20'h0_0000;
    cut_mask = 20'h0_0000;
    case (q.pend_mode)
      lpmc_pkg::MODE_IDLE: stop_mask = lpmc_pkg::IDLE_STOPCLK;
      lpmc_pkg::MODE_STOP_WITH_SUPPLY_MODE:
        stop_mask = lpmc_pkg::STOP_WITH_SUPPLY_MODE_STOPCLK | (lpmc_pkg::STOP_WITH_SUPPLY_MODE_SEL & ~q.keeprun);
      lpmc_pkg::MODE_POWER_CUT_STOP_MODE: begin
        stop_mask = lpmc_pkg::POWER_CUT_STOP_MODE_STOPCLK;
        cut_mask = lpmc_pkg::POWER_CUT_STOP_MODE_CUT | (lpmc_pkg::POWER_CUT_STOP_MODE_SEL & ~q.keeprun);
      end
      default: stop_mask = 20'h0_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    d.rst_sync = 2'b11;
    // AXI write channel, address and data in either order
    if (s_axi_awvalid && !q.aw_got && !q.bvalid) begin
      d.aw_got = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q.w_got && !q.bvalid) begin
      d.w_got = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end
    if (q.aw_got && q.w_got) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = 2'b00;
      if (q.aw_addr == lpmc_pkg::ADDR_STBYCR) begin
        if (q.w_strb[0]) begin
          d.stby = q.w_data[lpmc_pkg::STBY_LSB +: 3];
        end
        if (q.w_strb[2]) begin
          d.drve = q.w_data[lpmc_pkg::DRVE_BIT];
          d.ptkeep = q.w_data[lpmc_pkg::PTKEEP_BIT];
        end
      end else if (q.aw_addr == lpmc_pkg::ADDR_KEEPRUN) begin
        if (q.w_strb[0]) d.keeprun[7:0] = q.w_data[7:0];
        if (q.w_strb[1]) d.keeprun[15:8] = q.w_data[15:8];
        if (q.w_strb[2]) d.keeprun[19:16] = q.w_data[19:16];
      end else if (q.aw_addr == lpmc_pkg::ADDR_STATUS) begin
        d.bresp = 2'b10;
      end else begin
        d.bresp = 2'b11;
      end
    end
    if (q.bvalid && s_axi_bready) d.bvalid = 1'b0;
    // AXI read channel
    if (s_axi_arvalid && !q.rvalid) begin
      d.rvalid = 1'b1;
      d.rresp = 2'b00;
      d.rdata = 32'h0000_0000;
      if (s_axi_araddr == lpmc_pkg::ADDR_STBYCR) begin
        d.rdata[lpmc_pkg::STBY_LSB +: 3] = q.stby;
        d.rdata[lpmc_pkg::DRVE_BIT] = q.drve;
        d.rdata[lpmc_pkg::PTKEEP_BIT] = q.ptkeep;
      end else if (s_axi_araddr == lpmc_pkg::ADDR_KEEPRUN) begin
        d.rdata[19:0] = q.keeprun;
      end else if (s_axi_araddr == lpmc_pkg::ADDR_STATUS) begin
        d.rdata[1:0] = q.state;
        d.rdata[2] = q.internal_fast_oscillator_sel;
        d.rdata[3] = q.hold;
      end else begin
        d.rresp = 2'b11;
      end
    end
    if (q.rvalid && s_axi_rready) d.rvalid = 1'b0;
    // Entry is armed by the wait-for-interrupt, not by the mode field
    case (q.state)
      lpmc_pkg::ST_RUN: begin
        if (wfi_exec && !q.pend) begin
          d.pend = 1'b1;
          d.pend_mode = q.stby;
        end
        // Undefined codes arm but never leave run, gates and supplies stay on
        if (q.pend && core_halted) begin
          d.pend = 1'b0;
          d.gate = ~stop_mask;
          d.supply = ~cut_mask;
          if (q.pend_mode == lpmc_pkg::MODE_IDLE) d.state = lpmc_pkg::ST_IDLE;
          else if (q.pend_mode == lpmc_pkg::MODE_STOP_WITH_SUPPLY_MODE) d.state = lpmc_pkg::ST_STOP_WITH_SUPPLY_MODE;
          else if (q.pend_mode == lpmc_pkg::MODE_POWER_CUT_STOP_MODE) begin
            d.state = lpmc_pkg::ST_POWER_CUT_STOP_MODE;
            d.hold = q.ptkeep;
          end else begin
            d.gate = {20{1'b1}};
            d.supply = {20{1'b1}};
          end
        end
        if (q.pend && wake_event) d.pend = 1'b0;
      end
      default: begin
        if (wake_event) begin
          d.state = lpmc_pkg::ST_RUN;
          d.gate = {20{1'b1}};
          d.supply = {20{1'b1}};
          if (q.state != lpmc_pkg::ST_IDLE) d.internal_fast_oscillator_sel = 1'b1;
        end
      end
    endcase
    // Port hold persists until software drops the hold bit
    if (q.state == lpmc_pkg::ST_RUN && !q.ptkeep) d.hold = 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
      q.stby <= lpmc_pkg::STBY_RESET;
      q.keeprun <= lpmc_pkg::KEEPRUN_RESET;
      q.state <= lpmc_pkg::ST_RUN;
      q.internal_fast_oscillator_sel <= 1'b1;
      q.gate <= {20{1'b1}};
      q.supply <= {20{1'b1}};
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign s_axi_awready = !q.aw_got && !q.bvalid;
  assign s_axi_wready = !q.w_got && !q.bvalid;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  // Always-on modules forced on regardless of matrix
  assign clk_gate_en = q.gate | (20'h1 << lpmc_pkg::M_RMC) | (20'h1 << lpmc_pkg::M_RTC)
    | (20'h1 << lpmc_pkg::M_LVD);
  assign supply_en = q.supply | (20'h1 << lpmc_pkg::M_RMC) | (20'h1 << lpmc_pkg::M_RTC)
    | (20'h1 << lpmc_pkg::M_LVD);
  assign wdt_run = clk_gate_en[lpmc_pkg::M_WDT];
  assign wdt_clear = wdt_clear_req && (q.state != lpmc_pkg::ST_IDLE);
  assign port_drive_en = (q.state == lpmc_pkg::ST_STOP_WITH_SUPPLY_MODE) ? q.drve : 1'b1;
  // Hold outlives the wake so pins stay put until software restores the ports
  assign port_hold = q.hold;
  assign sysclk_from_internal_fast_oscillator = q.internal_fast_oscillator_sel;
  assign in_standby = (q.state != lpmc_pkg::ST_RUN);

  ////////////////////////////////////////////////////////////////////////
  sequence s_armed;
    q.pend && core_halted && q.pend_mode == lpmc_pkg::MODE_POWER_CUT_STOP_MODE;
  endsequence
  a_no_entry_wo_wfi: assert property (@(posedge clk) disable iff (!rst_n_i)
    q.state == lpmc_pkg::ST_RUN && !q.pend && !wfi_exec |=> q.state == lpmc_pkg::ST_RUN)
    else $error("standby entered without wfi");
  a_power_cut_stop_mode_cut: assert property (@(posedge clk) disable iff (!rst_n_i)
    s_armed |=> !supply_en[lpmc_pkg::M_CORE] && !supply_en[lpmc_pkg::M_EBI])
    else $error("power_cut_stop_mode supply not cut");
  a_idle_core_only: assert property (@(posedge clk) disable iff (!rst_n_i)
    q.state == lpmc_pkg::ST_IDLE |-> clk_gate_en == 20'hF_FFFE)
    else $error("idle gating wrong");
  a_always_on: assert property (@(posedge clk) disable iff (!rst_n_i)
    clk_gate_en[lpmc_pkg::M_RTC] && supply_en[lpmc_pkg::M_RMC] && supply_en[lpmc_pkg::M_LVD])
    else $error("always-on module stopped");
  a_wdt_no_clear: assert property (@(posedge clk) disable iff (!rst_n_i)
    q.state == lpmc_pkg::ST_IDLE |-> !wdt_clear && wdt_run)
    else $error("watchdog cleared in idle");
  a_stop_with_supply_mode_drive: assert property (@(posedge clk) disable iff (!rst_n_i)
    q.state == lpmc_pkg::ST_STOP_WITH_SUPPLY_MODE |-> port_drive_en == q.drve)
    else $error("stop_with_supply_mode drive wrong");
  a_power_cut_stop_mode_hold: assert property (@(posedge clk) disable iff (!rst_n_i)
    (s_armed and q.ptkeep) |=> port_hold)
    else $error("ports not held");
  a_wake_internal_fast_oscillator: assert property (@(posedge clk) disable iff (!rst_n_i)
    (q.state == lpmc_pkg::ST_STOP_WITH_SUPPLY_MODE || q.state == lpmc_pkg::ST_POWER_CUT_STOP_MODE) && wake_event
    |=> sysclk_from_internal_fast_oscillator && q.state == lpmc_pkg::ST_RUN)
    else $error("no internal_fast_oscillator after wake");
  a_stop_with_supply_mode_keep: assert property (@(posedge clk) disable iff (!rst_n_i)
    q.pend && core_halted && q.pend_mode == lpmc_pkg::MODE_STOP_WITH_SUPPLY_MODE && q.keeprun[lpmc_pkg::M_PLL]
    |=> clk_gate_en[lpmc_pkg::M_PLL] && !clk_gate_en[lpmc_pkg::M_CORE])
    else $error("stop_with_supply_mode keep-run ignored");
endmodule // lpmc_top
`default_nettype wire

// [verif/test_low_power_mode_controller.sv]
`timescale 1ns/1ns
`default_nettype none
module test_low_power_mode_controller;
  logic clk, reset_n, wfi_exec, core_halted, wake_event, wdt_clear_req;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic wdt_clear, wdt_run, port_drive_en, port_hold, sysclk_from_internal_fast_oscillator, in_standby;
  logic [19:0] clk_gate_en, supply_en, keep;
  int fail_count = 0;
  int n_tests = 0;
  int cycles = 0;

  lpmc_top dut_u (.clk, .reset_n, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .wfi_exec, .core_halted,
    .wake_event, .wdt_clear_req, .wdt_clear, .wdt_run, .clk_gate_en, .supply_en,
    .port_drive_en, .port_hold, .sysclk_from_internal_fast_oscillator, .in_standby);

  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("counts: %0d compared, %0d mismatched", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      summarize();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic pa, pw;
    pa = 1;
    pw = 1;
    @(posedge clk);
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    while (pa || pw) begin
      @(posedge clk);
      if (pa && s_axi_awready) begin
        pa = 0;
        s_axi_awvalid <= 0;
      end
      if (pw && s_axi_wready) begin
        pw = 0;
        s_axi_wvalid <= 0;
      end
    end
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 0;
  endtask

  task automatic rdr(input logic [7:0] a);
    @(posedge clk);
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    s_axi_araddr <= a;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    while (s_axi_rvalid !== 1'b1) @(posedge clk);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 0;
  endtask

  task automatic go();
    @(posedge clk);
    {wfi_exec, core_halted} <= 2'b11;
    @(posedge clk);
    wfi_exec <= 0;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic wake();
    @(posedge clk);
    {wake_event, core_halted} <= 2'b10;
    @(posedge clk);
    wake_event <= 0;
    repeat (3) @(posedge clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n = 0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {wfi_exec, core_halted, wake_event} = '0;
    wdt_clear_req = 1;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    repeat (6) @(posedge clk);
    reset_n <= 1;
    repeat (3) @(posedge clk);
    rdr(lpmc_pkg::ADDR_STBYCR);
    chk("stby reset", rd, 32'h0000_0003);
    rdr(lpmc_pkg::ADDR_KEEPRUN);
    chk("keep reset", rd, 32'h0000_0000);
    rdr(lpmc_pkg::ADDR_STATUS);
    chk("status reset", rd, 32'h0000_0004);
    wr(lpmc_pkg::ADDR_STATUS, 32'h0000_0000);
    chk("ro bresp", rsp, 2'h2);
    wr(8'h0C, 32'h0000_0000);
    chk("unmapped bresp", rsp, 2'h3);
    rdr(8'h0C);
    chk("unmapped rresp", rsp, 2'h3);
    chk("unmapped rdata", rd, 32'h0000_0000);
    chk("gates reset", clk_gate_en, 20'hF_FFFF);
    repeat (4) @(posedge clk);
    chk("no wfi", in_standby, 1'b0);
    wr(lpmc_pkg::ADDR_STBYCR, 32'h0000_0007);
    go();
    chk("bad code", in_standby, 1'b0);
    wake();
    $display("test registers done");
    wr(lpmc_pkg::ADDR_STBYCR, {29'h0, lpmc_pkg::MODE_IDLE});
    go();
    chk("idle gates", clk_gate_en, 20'(~lpmc_pkg::IDLE_STOPCLK));
    chk("idle wdt run", wdt_run, 1'b1);
    chk("idle wdt clr", wdt_clear, 1'b0);
    chk("idle supply", supply_en, 20'hF_FFFF);
    rdr(lpmc_pkg::ADDR_STATUS);
    chk("idle status", rd, 32'h0000_0005);
    wake();
    chk("run wdt clr", wdt_clear, 1'b1);
    chk("run gates", clk_gate_en, 20'hF_FFFF);
    $display("test idle done");
    for (int i = 0; i < 4; i++) begin
      keep = i[0] ? lpmc_pkg::STOP_WITH_SUPPLY_MODE_SEL : 20'h0_0000;
      wr(lpmc_pkg::ADDR_KEEPRUN, {12'h000, keep});
      wr(lpmc_pkg::ADDR_STBYCR, {15'h0000, i[1], 13'h0000, lpmc_pkg::MODE_STOP_WITH_SUPPLY_MODE});
      go();
      chk("stop_with_supply_mode gates", clk_gate_en,
        20'(~lpmc_pkg::STOP_WITH_SUPPLY_MODE_STOPCLK & ~(lpmc_pkg::STOP_WITH_SUPPLY_MODE_SEL & ~keep)));
      chk("stop_with_supply_mode drive", port_drive_en, i[1]);
      chk("stop_with_supply_mode supply", supply_en, 20'hF_FFFF);
      rdr(lpmc_pkg::ADDR_STATUS);
      chk("stop_with_supply_mode status", rd, 32'h0000_0007);
      wake();
      chk("stop_with_supply_mode exit clk", sysclk_from_internal_fast_oscillator, 1'b1);
    end
    $display("test stop_with_supply_mode done");
    // Hold captured from the keep bit level on power_cut_stop_mode entry
    for (int i = 0; i < 2; i++) begin
      keep = i[0] ? lpmc_pkg::POWER_CUT_STOP_MODE_SEL : 20'h0_0000;
      wr(lpmc_pkg::ADDR_KEEPRUN, {12'h000, keep});
      wr(lpmc_pkg::ADDR_STBYCR, {14'h0000, !i[0], 14'h0000, lpmc_pkg::MODE_POWER_CUT_STOP_MODE});
      go();
      chk("power_cut_stop_mode supply", supply_en,
        20'(~lpmc_pkg::POWER_CUT_STOP_MODE_CUT & ~(lpmc_pkg::POWER_CUT_STOP_MODE_SEL & ~keep)));
      chk("power_cut_stop_mode stopclk", clk_gate_en & lpmc_pkg::POWER_CUT_STOP_MODE_STOPCLK, 20'h0_0000);
      chk("power_cut_stop_mode on", clk_gate_en & 20'h0_3800, 20'h0_3800);
      chk("power_cut_stop_mode hold", port_hold, !i[0]);
      wake();
      chk("power_cut_stop_mode exit clk", sysclk_from_internal_fast_oscillator, 1'b1);
      chk("exit supply", supply_en, 20'hF_FFFF);
      chk("exit hold", port_hold, !i[0]);
      wr(lpmc_pkg::ADDR_STBYCR, {29'h0, lpmc_pkg::MODE_POWER_CUT_STOP_MODE});
      repeat (2) @(posedge clk);
      #1;
      chk("hold release", port_hold, 1'b0);
    end
    $display("test power_cut_stop_mode done");
    summarize();
  end
endmodule // test_low_power_mode_controller
`default_nettype wire
